// ### src/mfe_edge_gen.sv
// Purpose: turns accepted line requests into one-cycle edges on the line outputs
// Assumes: at most one request per cycle
// Notes:   a request hitting a line high this cycle is held one cycle so edges stay apart
module mfe_edge_gen
  import mfe_pkg::*;
(
  input  logic                 mclk,
  input  logic                 nrst,
  mfe_req_if.snk               req,
  input  logic [NUM_LINES-1:0] alloc_mask,
  output logic [NUM_LINES-1:0] line_q
);

  logic [NUM_LINES-1:0] pend_q;
  wire  [NUM_LINES-1:0] req_vec  = req.hit ? (NUM_LINES'(1) << req.hit_id) : '0;
  wire  [NUM_LINES-1:0] fire     = (req_vec | pend_q) & alloc_mask;
  // a third write to one line inside three cycles merges with the held one
  wire  [NUM_LINES-1:0] line_d   = fire & ~line_q;
  wire  [NUM_LINES-1:0] pend_d   = fire & line_q;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      line_q <= '0;
      pend_q <= '0;
    end else begin
      line_q <= line_d;
      pend_q <= pend_d;
    end
  end

endmodule : mfe_edge_gen

// ### src/mfe_line_check.sv
// Purpose: decides whether a requested line belongs to the addressed frame
// Assumes: request already decoded as a set-line write
// Notes:   purely combinational
module mfe_line_check
  import mfe_pkg::*;
(
  mfe_req_if.chk req
);

  // ----------------------------------------------------------------------
  // frame ownership
  // ----------------------------------------------------------------------
  wire sec_ok  = (req.frame != SEC_FRAME) || req.secure;
  wire own_ok  = frame_exists(req.frame) && in_span(req.id, req.frame);

  assign req.hit    = req.valid && sec_ok && own_ok;
  assign req.hit_id = req.id;

endmodule : mfe_line_check

// ### src/mfe_pkg.sv
// Purpose: constants, line allocation and helpers for the message interrupt edge frames
// Assumes: one clock, frame offsets are 12-bit byte offsets inside a 4 KB frame
// Notes:   frame index 0..NS_FRAMES-1 are non-secure, index SEC_FRAME is the secure frame
package mfe_pkg;

  // ----------------------------------------------------------------------
  // build options
  // ----------------------------------------------------------------------
  localparam bit          CTRL_SEC_EXT  = 1'b1;
  localparam bit          FRAME_SEC_EXT = 1'b1;
  // the frame extension is only legal on a controller with its own security
  localparam bit          SEC_EN        = FRAME_SEC_EXT & CTRL_SEC_EXT;
  localparam int          NS_FRAMES     = 2;
  localparam int          FRAME_W       = 2;
  localparam logic [1:0]  SEC_FRAME     = 2'h2;

  // ----------------------------------------------------------------------
  // line allocation
  // ----------------------------------------------------------------------
  localparam int          ID_W          = 10;
  localparam int          NUM_LINES     = 1020;
  localparam logic [9:0]  NS_BASE       = 10'h040;
  localparam logic [9:0]  NS_SPAN       = 10'h020;
  localparam logic [9:0]  SEC_BASE      = 10'h0a0;
  localparam logic [9:0]  SEC_SPAN      = 10'h010;

  // ----------------------------------------------------------------------
  // frame layout
  // ----------------------------------------------------------------------
  localparam int          ADDR_W        = 12;
  localparam logic [11:0] OFS_TYPER     = 12'h008;
  localparam logic [11:0] OFS_SETLINE   = 12'h040;
  localparam logic [11:0] OFS_IDENT     = 12'hfcc;
  localparam logic [3:0]  BE_WORD       = 4'hf;
  localparam logic [3:0]  BE_HALF_LO    = 4'h3;
  localparam int          TYPER_BASE_LSB = 16;
  localparam int          TYPER_SPAN_LSB = 0;
  // identification values are arbitrary
  localparam logic [11:0] IDENT_PRODUCT = 12'h5a1;
  localparam logic [3:0]  IDENT_ARCH    = 4'h0;
  localparam logic [3:0]  IDENT_REV     = 4'h1;
  localparam logic [11:0] IDENT_MAKER   = 12'h07e;
  localparam logic [31:0] RD_RESET      = 32'h0000_0000;

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  function automatic logic [9:0] frame_base(input logic [1:0] f);
    return (f == SEC_FRAME) ? SEC_BASE : 10'(NS_BASE + NS_SPAN * f);
  endfunction : frame_base

  function automatic logic [9:0] frame_span(input logic [1:0] f);
    return (f == SEC_FRAME) ? SEC_SPAN : NS_SPAN;
  endfunction : frame_span

  function automatic logic frame_exists(input logic [1:0] f);
    return (f == SEC_FRAME) ? SEC_EN : (int'(f) < NS_FRAMES);
  endfunction : frame_exists

  function automatic logic in_span(input logic [9:0] id, input logic [1:0] f);
    logic [10:0] top;
    top = {1'b0, frame_base(f)} + {1'b0, frame_span(f)};
    return (id >= frame_base(f)) && ({1'b0, id} < top);
  endfunction : in_span

  function automatic logic [31:0] typer_word(input logic [1:0] f);
    return {6'h00, frame_base(f), 6'h00, frame_span(f)};
  endfunction : typer_word

endpackage : mfe_pkg

// ### src/mfe_req_if.sv
// Purpose: carries one decoded line request from the top to the checker and the pulser
// Assumes: all signals on mclk
// Notes:   hit and hit_id are driven by the checker
interface mfe_req_if;
  import mfe_pkg::*;
  logic               valid;
  logic [1:0]         frame;
  logic               secure;
  logic [ID_W-1:0]    id;
  logic               hit;
  logic [ID_W-1:0]    hit_id;

  modport src (output valid, frame, secure, id, input hit, hit_id);
  modport chk (input valid, frame, secure, id, output hit, hit_id);
  modport snk (input hit, hit_id);
endinterface : mfe_req_if

// ### src/mfe_top.sv
// Purpose: message interrupt frames driving edges into a shared interrupt controller
// Assumes: requesters and software sit on mclk; writes and reads are single-cycle strobes
// Notes:   no bus fabric: each access names its frame, offset and security, and writes also name their byte lanes

// What this block does
// - message write drives edge on its line
// - only a subset of lines is driven
// - optional secure frame beside non-secure frames
// - frame security needs controller security
// - without frame security all messages non-secure
// - several non-secure frame instances supported
// - each non-secure frame owns contiguous lines
// - secure frame owns its own contiguous lines
// - secure and non-secure ranges never overlap
// - message lines driven by frames only
// - set write raises line named by bits 9:0
// - unowned line number ignores the write
// - type register gives base and count
// - word access, plus halfword set writes
module mfe_top
  import mfe_pkg::*;
(
  input  logic                 mclk,
  input  logic                 nrst,
  input  logic                 wr_valid,
  input  logic [FRAME_W-1:0]   wr_frame,
  input  logic                 wr_secure,
  input  logic [ADDR_W-1:0]    wr_addr,
  input  logic [3:0]           wr_be,
  input  logic [31:0]          wr_data,
  output logic                 wr_taken,
  input  logic                 rd_valid,
  input  logic [FRAME_W-1:0]   rd_frame,
  input  logic                 rd_secure,
  input  logic [ADDR_W-1:0]    rd_addr,
  output logic                 rd_ack_q,
  output logic                 rd_err_q,
  output logic [31:0]          rd_data_q,
  output logic [NUM_LINES-1:0] spi_line,
  output logic [NUM_LINES-1:0] sec_line_map
);

  // ----------------------------------------------------------------------
  // line allocation masks
  // ----------------------------------------------------------------------
  logic [NUM_LINES-1:0] alloc_mask;
  logic [NUM_LINES-1:0] sec_mask;
  logic [NUM_LINES-1:0] ns_mask;

  always_comb begin
    alloc_mask = '0;
    sec_mask   = '0;
    ns_mask    = '0;
    for (int i = 0; i < NUM_LINES; i++) begin
      for (int f = 0; f < NS_FRAMES; f++) begin
        if (in_span(10'(i), 2'(f))) begin
          ns_mask[i] = 1'b1;
        end
      end
      if (SEC_EN && in_span(10'(i), SEC_FRAME)) begin
        sec_mask[i] = 1'b1;
      end
    end
    alloc_mask = ns_mask | sec_mask;
  end

  // without the frame extension no message line is ever reported secure
  assign sec_line_map = SEC_EN ? sec_mask : '0;

  // ----------------------------------------------------------------------
  // write decode
  // ----------------------------------------------------------------------
  wire wr_size_ok  = (wr_be == BE_WORD) || (wr_be == BE_HALF_LO);
  wire wr_is_set   = wr_valid && (wr_addr == OFS_SETLINE) && wr_size_ok;
  wire [ID_W-1:0] wr_id = wr_data[ID_W-1:0];

  mfe_req_if req ();

  assign req.valid  = wr_is_set;
  assign req.frame  = wr_frame;
  assign req.secure = wr_secure;
  assign req.id     = wr_id;
  assign wr_taken   = req.hit;

  mfe_line_check u_check (
    .req (req)
  );

  mfe_edge_gen u_edge (
    .mclk       (mclk),
    .nrst       (nrst),
    .req        (req),
    .alloc_mask (alloc_mask),
    .line_q     (spi_line)
  );

  // ----------------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------------
  wire rd_frame_ok = frame_exists(rd_frame);
  wire rd_sec_ok   = (rd_frame != SEC_FRAME) || rd_secure;
  wire rd_good     = rd_valid && rd_frame_ok && rd_sec_ok;
  wire [31:0] ident_word = {IDENT_PRODUCT, IDENT_ARCH, IDENT_REV, IDENT_MAKER};
  // set-line registers are write-only and reserved space reads zero
  wire [31:0] rd_word =
    !rd_good                 ? RD_RESET :
    (rd_addr == OFS_TYPER)   ? typer_word(rd_frame) :
    (rd_addr == OFS_IDENT)   ? ident_word : RD_RESET;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rd_ack_q  <= 1'b0;
      rd_err_q  <= 1'b0;
      rd_data_q <= RD_RESET;
    end else begin
      rd_ack_q  <= rd_valid;
      rd_err_q  <= rd_valid && !rd_good;
      rd_data_q <= rd_valid ? rd_word : rd_data_q;
    end
  end

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  logic [ID_W-1:0] hit_id_q;
  logic            hit_free_q;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      hit_id_q   <= '0;
      hit_free_q <= 1'b0;
    end else begin
      hit_id_q   <= req.hit_id;
      hit_free_q <= req.hit && !spi_line[req.hit_id];
    end
  end

  a_edge_follows_write: assert property (
    hit_free_q |-> spi_line[hit_id_q]
  ) else $error("accepted write gave no edge");

  a_pulse_one_cycle: assert property (
    spi_line[hit_id_q] && hit_free_q |=> !spi_line[$past(hit_id_q)]
  ) else $error("line pulse wider than one cycle");

  a_lines_allocated_only: assert property (
    (spi_line & ~alloc_mask) == '0
  ) else $error("unallocated line driven");

  a_ranges_disjoint: assert property (
    (sec_mask & ns_mask) == '0
  ) else $error("secure and non-secure ranges overlap");

  a_secure_frame_guard: assert property (
    wr_is_set && (wr_frame == SEC_FRAME) && !wr_secure |-> !wr_taken
  ) else $error("non-secure access took the secure frame");

  a_foreign_line_ignored: assert property (
    wr_is_set && !in_span(wr_id, wr_frame) |-> !wr_taken
  ) else $error("write outside frame range accepted");

  a_typer_read_fields: assert property (
    rd_good && (rd_addr == OFS_TYPER)
      |=> rd_ack_q && (rd_data_q[25:16] == frame_base($past(rd_frame)))
          && (rd_data_q[9:0] == frame_span($past(rd_frame)))
  ) else $error("type register fields wrong");

  a_half_write_taken: assert property (
    wr_valid && (wr_addr == OFS_SETLINE) && (wr_be == BE_HALF_LO)
      && (wr_frame != SEC_FRAME) && frame_exists(wr_frame)
      && in_span(wr_id, wr_frame) |-> wr_taken
  ) else $error("halfword set write refused");

  a_odd_size_refused: assert property (
    wr_valid && !wr_size_ok |-> !wr_taken
  ) else $error("unsupported access size accepted");

  a_nonsecure_map: assert property (
    wr_taken && (!SEC_EN || (wr_frame != SEC_FRAME)) |-> !sec_line_map[wr_id]
  ) else $error("non-secure message reached a secure line");

  a_bad_read_flagged: assert property (
    rd_valid && !rd_sec_ok |=> rd_err_q && (rd_data_q == RD_RESET)
  ) else $error("insecure read of secure frame not flagged");

  a_taken_needs_set: assert property (
    wr_taken |-> wr_valid && (wr_addr == OFS_SETLINE)
  ) else $error("line taken without a set write");

  // a held edge may trail its write by two cycles
  a_no_spurious_edge: assert property (
    (spi_line != '0) |-> $past(wr_taken) || $past(wr_taken, 2)
  ) else $error("line edge without an accepted write");

  a_read_ack_timing: assert property (
    rd_ack_q == $past(rd_valid)
  ) else $error("read answer not one cycle after request");

  a_read_data_held: assert property (
    !rd_valid |=> $stable(rd_data_q)
  ) else $error("read data changed without a read");

  a_ident_read: assert property (
    rd_good && (rd_addr == OFS_IDENT)
      |=> rd_data_q == {IDENT_PRODUCT, IDENT_ARCH, IDENT_REV, IDENT_MAKER}
  ) else $error("identification word wrong");

  a_reserved_reads_zero: assert property (
    rd_valid && (rd_addr != OFS_TYPER) && (rd_addr != OFS_IDENT) |=> rd_data_q == RD_RESET
  ) else $error("reserved offset read nonzero");

  c_ns_write: cover property (wr_taken && (wr_frame == 2'h0));
  c_sec_write: cover property (wr_taken && (wr_frame == SEC_FRAME));
  c_back_to_back: cover property (wr_taken ##1 wr_taken && (req.hit_id == hit_id_q));
  c_typer_read: cover property (rd_good && (rd_addr == OFS_TYPER));
  c_half_write: cover property (wr_taken && (wr_be == BE_HALF_LO));

endmodule : mfe_top

// ### tb/mfe_dist_model.sv
// Purpose: distributor stand-in that counts rising edges on the lines
// Assumes: software set every message line edge-triggered
// Notes:   levels are ignored, so a stuck line counts once
module mfe_dist_model
  import mfe_pkg::*;
(
  input wire logic                 mclk,
  input wire logic                 nrst,
  input wire logic [NUM_LINES-1:0] spi_line,
  input wire logic [NUM_LINES-1:0] sec_line_map,
  output logic [15:0]              edge_cnt,
  output logic [15:0]              g0_cnt,
  output logic [15:0]              g1_cnt
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [NUM_LINES-1:0] prev_q;
  // software setup kept here: secure-frame lines in group 0, all other
  // message lines non-secure in group 1, none handed over by access control
  wire  [NUM_LINES-1:0] grp0 = sec_line_map;
  wire  [NUM_LINES-1:0] grp1 = ~sec_line_map;
  wire  [NUM_LINES-1:0] rise = spi_line & ~prev_q;
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      prev_q   <= '0;
      edge_cnt <= '0;
      g0_cnt   <= '0;
      g1_cnt   <= '0;
    end else begin
      prev_q   <= spi_line;
      edge_cnt <= edge_cnt + 16'($countones(rise));
      g0_cnt   <= g0_cnt + 16'($countones(rise & grp0));
      g1_cnt   <= g1_cnt + 16'($countones(rise & grp1));
    end
  end
endmodule : mfe_dist_model

// ### tb/mfe_top_bench.sv
// Purpose: self-checking bench for the message interrupt edge frames
// Assumes: inputs change 1 ns after the rising edge
// Notes:   expectations come from package constants plus literal line numbers, flags and zero words
module mfe_top_bench
  import mfe_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic                 mclk, nrst, wr_valid, wr_secure, wr_taken;
  logic                 rd_valid, rd_secure, rd_ack_q, rd_err_q;
  logic [1:0]           wr_frame, rd_frame;
  logic [11:0]          wr_addr, rd_addr;
  logic [3:0]           wr_be;
  logic [31:0]          wr_data, rd_data_q, n_edges, n_sec;
  logic [15:0]          edge_cnt, g0_cnt, g1_cnt;
  logic [NUM_LINES-1:0] spi_line, sec_line_map;
  int                   n_errors, total_checks;

  mfe_top u_dut (.mclk(mclk), .nrst(nrst), .wr_valid(wr_valid), .wr_frame(wr_frame),
    .wr_secure(wr_secure), .wr_addr(wr_addr), .wr_be(wr_be), .wr_data(wr_data),
    .wr_taken(wr_taken), .rd_valid(rd_valid), .rd_frame(rd_frame), .rd_secure(rd_secure),
    .rd_addr(rd_addr), .rd_ack_q(rd_ack_q), .rd_err_q(rd_err_q), .rd_data_q(rd_data_q),
    .spi_line(spi_line), .sec_line_map(sec_line_map));
  mfe_dist_model u_dist (.mclk(mclk), .nrst(nrst), .spi_line(spi_line),
    .sec_line_map(sec_line_map), .edge_cnt(edge_cnt), .g0_cnt(g0_cnt), .g1_cnt(g1_cnt));

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  task automatic step();
    @(posedge mclk);
    #1;
  endtask : step

  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    total_checks++;
    if (exp !== got) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic close_out();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : close_out

  task automatic put(logic [1:0] f, logic s, logic [11:0] a, logic [3:0] be, logic [31:0] d);
    wr_frame = f;
    wr_secure = s;
    wr_addr = a;
    wr_be = be;
    wr_data = d;
    wr_valid = 1'b1;
  endtask : put

  // one write, its same-cycle answer and the one-cycle pulse that follows
  task automatic wr(logic [1:0] f, logic s, logic [11:0] a, logic [3:0] be, logic [31:0] d,
                    logic ok);
    logic [NUM_LINES-1:0] exp;
    exp = '0;
    if (ok)
      exp[d[9:0]] = 1'b1;
    put(f, s, a, be, d);
    #1 chk("wr_taken", ok, wr_taken);
    step();
    wr_valid = 1'b0;
    chk("pulse", 1, spi_line === exp);
    step();
    chk("pulse end", 1, spi_line === '0);
    n_edges = n_edges + ok;
    n_sec = n_sec + (ok && (f == SEC_FRAME));
  endtask : wr

  task automatic rd(logic [1:0] f, logic s, logic [11:0] a, logic err, logic [31:0] d);
    rd_frame = f;
    rd_secure = s;
    rd_addr = a;
    rd_valid = 1'b1;
    step();
    rd_valid = 1'b0;
    chk("rd_ack_q", 1, rd_ack_q);
    chk("rd_err_q", err, rd_err_q);
    chk("rd_data_q", d, rd_data_q);
    step();
  endtask : rd

  task automatic t_accept();
    wr(2'h0, 1'b0, OFS_SETLINE, BE_WORD, 32'h40, 1'b1);
    wr(2'h0, 1'b0, OFS_SETLINE, BE_WORD, 32'h5f, 1'b1);
    wr(2'h1, 1'b1, OFS_SETLINE, BE_WORD, 32'h60, 1'b1);
    wr(2'h2, 1'b1, OFS_SETLINE, BE_WORD, 32'ha0, 1'b1);
    wr(2'h2, 1'b1, OFS_SETLINE, BE_WORD, 32'haf, 1'b1);
    wr(2'h0, 1'b0, OFS_SETLINE, BE_HALF_LO, 32'hffff_0045, 1'b1);
  endtask : t_accept

  task automatic t_refuse();
    wr(2'h0, 1'b0, OFS_SETLINE, BE_WORD, 32'h60, 1'b0);
    wr(2'h1, 1'b0, OFS_SETLINE, BE_WORD, 32'h3f, 1'b0);
    wr(2'h2, 1'b0, OFS_SETLINE, BE_WORD, 32'ha0, 1'b0);
    wr(2'h2, 1'b1, OFS_SETLINE, BE_WORD, 32'hb0, 1'b0);
    wr(2'h0, 1'b1, OFS_SETLINE, BE_WORD, 32'ha0, 1'b0);
    wr(2'h3, 1'b1, OFS_SETLINE, BE_WORD, 32'h40, 1'b0);
    wr(2'h0, 1'b0, OFS_SETLINE, BE_WORD, 32'h20, 1'b0);
    wr(2'h0, 1'b0, OFS_TYPER, BE_WORD, 32'h40, 1'b0);
    wr(2'h0, 1'b0, OFS_SETLINE, 4'h1, 32'h40, 1'b0);
  endtask : t_refuse

  // back-to-back writes, same line then two neighbours
  task automatic t_burst();
    logic [15:0] base;
    base = edge_cnt;
    put(2'h0, 1'b0, OFS_SETLINE, BE_WORD, 32'h46);
    step();
    chk("same 1st", 1, spi_line[70]);
    step();
    wr_valid = 1'b0;
    chk("same gap", 0, spi_line[70]);
    repeat (4) step();
    chk("same edges", base + 2, edge_cnt);
    put(2'h0, 1'b0, OFS_SETLINE, BE_WORD, 32'h40);
    step();
    put(2'h0, 1'b0, OFS_SETLINE, BE_WORD, 32'h41);
    chk("pair 1st", 1, spi_line[64]);
    step();
    wr_valid = 1'b0;
    chk("pair 2nd", 1, spi_line[65] & ~spi_line[64]);
    step();
    n_edges = n_edges + 4;
  endtask : t_burst

  task automatic t_reads();
    rd(2'h0, 1'b0, OFS_TYPER, 1'b0, {6'h00, NS_BASE, 6'h00, NS_SPAN});
    rd(2'h1, 1'b0, OFS_TYPER, 1'b0, {6'h00, NS_BASE + NS_SPAN, 6'h00, NS_SPAN});
    rd(2'h2, 1'b1, OFS_TYPER, 1'b0, {6'h00, SEC_BASE, 6'h00, SEC_SPAN});
    rd(2'h2, 1'b0, OFS_TYPER, 1'b1, 32'h0);
    rd(2'h3, 1'b1, OFS_TYPER, 1'b1, 32'h0);
    rd(2'h1, 1'b0, OFS_IDENT, 1'b0, {IDENT_PRODUCT, IDENT_ARCH, IDENT_REV, IDENT_MAKER});
    rd(2'h0, 1'b0, 12'h000, 1'b0, 32'h0);
    step();
    chk("ack end", 0, rd_ack_q);
  endtask : t_reads

  task automatic t_map();
    logic [NUM_LINES-1:0] m;
    m = '0;
    for (int i = 0; i < SEC_SPAN; i++)
      m[SEC_BASE + i] = 1'b1;
    chk("sec_line_map", 1, sec_line_map === m);
  endtask : t_map

  initial begin
    {nrst, wr_valid, rd_valid, wr_secure, rd_secure} = '0;
    {wr_frame, rd_frame, wr_addr, rd_addr, wr_be, wr_data} = '0;
    {n_edges, n_sec, n_errors, total_checks} = '0;
    repeat (12) step();
    chk("reset line", 1, spi_line === '0);
    chk("reset ack", 0, rd_ack_q);
    nrst = 1'b1;
    t_accept();
    t_refuse();
    t_burst();
    t_reads();
    t_map();
    chk("edge total", n_edges, edge_cnt);
    chk("group 0 edges", n_sec, g0_cnt);
    chk("group 1 edges", n_edges - n_sec, g1_cnt);
    close_out();
  end

  // the run needs about 66 cycles
  initial begin
    #100000;
    n_errors++;
    close_out();
  end
endmodule : mfe_top_bench
